// ### logic/homing_pkg.sv
// Constants and types for the homing sequencer (methods 17 to 23).
// Assumes one clock domain; the motion controller supplies speeds and ramps.
package homing_pkg;

  // ==========================================================================
  // Homing method numbers
  localparam logic [7:0] MODE_NEG_LIMIT = 8'h11; // 17
  localparam logic [7:0] MODE_POS_LIMIT = 8'h12; // 18
  localparam logic [7:0] MODE_HOME_19 = 8'h13;
  localparam logic [7:0] MODE_HOME_20 = 8'h14;
  localparam logic [7:0] MODE_HOME_21 = 8'h15;
  localparam logic [7:0] MODE_HOME_22 = 8'h16;
  localparam logic [7:0] MODE_HOME_23 = 8'h17;

  // ==========================================================================
  // Switch selectors, index into the synchronised switch vector
  localparam logic [1:0] SW_NEG = 2'h0;
  localparam logic [1:0] SW_POS = 2'h1;
  localparam logic [1:0] SW_HOME = 2'h2;

  // ==========================================================================
  // Values after reset
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [1:0] STEP_RST = 2'h0;
  localparam logic [2:0] SW_RST = 3'h0;

  // One move segment: direction, speed and the edge that ends it
  typedef struct packed {
    logic last;      // Stop of this segment is home
    logic dir_pos;   // 1 positive, 0 negative
    logic fast;      // 1 high search speed, 0 creep speed
    logic [1:0] sw;  // Switch watched
    logic to_active; // 1 inactive-to-active edge, 0 active-to-inactive
  } seg_t;

  typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_STOP, ST_ABORT} state_t;

endpackage

// ### logic/homing_sequencer.sv
// Homing sequencer for one servo axis, methods 17 to 23.
// Assumes a motion controller on clk that ramps to the commanded speed
// while move_run is high, decelerates when it drops, and reports standstill.
//
// Notes on behaviour
// - Mode 17, negative limit off: fast negative to its rise, creep positive to fall.
// - Mode 17, negative limit on: creep positive, stop at its falling edge as home.
// - Mode 18, positive limit off: fast positive to its rise, creep negative to fall.
// - Mode 18, positive limit on: creep negative, stop at its falling edge as home.
// - Mode 19, sensor off: fast positive to rise, creep negative to fall.
// - Mode 19, sensor on: fast negative to fall, fast back in, creep negative to fall.
// - Modes 19 to 22: either limit active aborts homing with alarm.
// - Mode 20, sensor off: fast positive to rise, fast back out, creep positive to rise.
// - Mode 20, sensor on: fast negative to fall, creep positive to rise.
// - Mode 21, sensor off: fast negative to rise, creep positive to fall.
// - Mode 21, sensor on: fast positive to fall, fast back in, creep positive to fall.
// - Mode 22, sensor off: fast negative to rise, fast back out, creep negative to rise.
// - Mode 22, sensor on: fast positive to fall, creep negative to rise.
// - Mode 23, sensor off past it: positive limit, back to fall, in, creep negative.
// - Mode 23, sensor off before it: fast positive to rise, creep negative to fall.
// - Mode 23, sensor on: fast negative to fall, fast back in, creep negative to fall.
// - Mode 23: reverse on first positive limit of the sensor-off opening run; negative or any other positive aborts.
`timescale 1ns/10ps

module homing_sequencer
  import homing_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Command side
  input wire logic start,
  input wire logic [7:0] mode,
  // Motion controller side
  input wire logic axis_stopped,
  output logic move_run,
  output logic move_dir_pos,
  output logic move_fast,
  // Status
  output logic busy,
  output logic home_set,
  output logic done,
  output logic alarm,
  // Switch pins, high means active
  input wire logic negative_limit_switch,
  input wire logic positive_limit_switch,
  input wire logic home_sensor_switch
);

  // ==========================================================================
  // Helpers

  function automatic seg_t mk(input logic last, input logic dir_pos, input logic fast,
                              input logic [1:0] sw, input logic to_active);
    seg_t s;
    s.last = last;
    s.dir_pos = dir_pos;
    s.fast = fast;
    s.sw = sw;
    s.to_active = to_active;
    return s;
  endfunction

  // Segment table; var_on is the watched switch level at start
  function automatic seg_t seg_lookup(input logic [7:0] m, input logic var_on, input logic [1:0] step);
    seg_t s;
    s = mk(1'b1, 1'b0, 1'b0, SW_HOME, 1'b0);
    case ({m, var_on, step})
      {MODE_NEG_LIMIT, 1'b0, 2'h0}: s = mk(1'b0, 1'b0, 1'b1, SW_NEG, 1'b1);
      {MODE_NEG_LIMIT, 1'b0, 2'h1}: s = mk(1'b1, 1'b1, 1'b0, SW_NEG, 1'b0);
      {MODE_NEG_LIMIT, 1'b1, 2'h0}: s = mk(1'b1, 1'b1, 1'b0, SW_NEG, 1'b0);
      {MODE_POS_LIMIT, 1'b0, 2'h0}: s = mk(1'b0, 1'b1, 1'b1, SW_POS, 1'b1);
      {MODE_POS_LIMIT, 1'b0, 2'h1}: s = mk(1'b1, 1'b0, 1'b0, SW_POS, 1'b0);
      {MODE_POS_LIMIT, 1'b1, 2'h0}: s = mk(1'b1, 1'b0, 1'b0, SW_POS, 1'b0);
      {MODE_HOME_19, 1'b0, 2'h0}: s = mk(1'b0, 1'b1, 1'b1, SW_HOME, 1'b1);
      {MODE_HOME_19, 1'b0, 2'h1}: s = mk(1'b1, 1'b0, 1'b0, SW_HOME, 1'b0);
      {MODE_HOME_19, 1'b1, 2'h0}: s = mk(1'b0, 1'b0, 1'b1, SW_HOME, 1'b0);
      {MODE_HOME_19, 1'b1, 2'h1}: s = mk(1'b0, 1'b1, 1'b1, SW_HOME, 1'b1);
      {MODE_HOME_19, 1'b1, 2'h2}: s = mk(1'b1, 1'b0, 1'b0, SW_HOME, 1'b0);
      {MODE_HOME_20, 1'b0, 2'h0}: s = mk(1'b0, 1'b1, 1'b1, SW_HOME, 1'b1);
      {MODE_HOME_20, 1'b0, 2'h1}: s = mk(1'b0, 1'b0, 1'b1, SW_HOME, 1'b0);
      {MODE_HOME_20, 1'b0, 2'h2}: s = mk(1'b1, 1'b1, 1'b0, SW_HOME, 1'b1);
      {MODE_HOME_20, 1'b1, 2'h0}: s = mk(1'b0, 1'b0, 1'b1, SW_HOME, 1'b0);
      {MODE_HOME_20, 1'b1, 2'h1}: s = mk(1'b1, 1'b1, 1'b0, SW_HOME, 1'b1);
      {MODE_HOME_21, 1'b0, 2'h0}: s = mk(1'b0, 1'b0, 1'b1, SW_HOME, 1'b1);
      {MODE_HOME_21, 1'b0, 2'h1}: s = mk(1'b1, 1'b1, 1'b0, SW_HOME, 1'b0);
      {MODE_HOME_21, 1'b1, 2'h0}: s = mk(1'b0, 1'b1, 1'b1, SW_HOME, 1'b0);
      {MODE_HOME_21, 1'b1, 2'h1}: s = mk(1'b0, 1'b0, 1'b1, SW_HOME, 1'b1);
      {MODE_HOME_21, 1'b1, 2'h2}: s = mk(1'b1, 1'b1, 1'b0, SW_HOME, 1'b0);
      // Back out of the sensor between fast and creep, mirroring mode 20
      {MODE_HOME_22, 1'b0, 2'h0}: s = mk(1'b0, 1'b0, 1'b1, SW_HOME, 1'b1);
      {MODE_HOME_22, 1'b0, 2'h1}: s = mk(1'b0, 1'b1, 1'b1, SW_HOME, 1'b0);
      {MODE_HOME_22, 1'b0, 2'h2}: s = mk(1'b1, 1'b0, 1'b0, SW_HOME, 1'b1);
      {MODE_HOME_22, 1'b1, 2'h0}: s = mk(1'b0, 1'b1, 1'b1, SW_HOME, 1'b0);
      {MODE_HOME_22, 1'b1, 2'h1}: s = mk(1'b1, 1'b0, 1'b0, SW_HOME, 1'b1);
      // Sensor off: side unknown until the sensor or the positive limit is met
      {MODE_HOME_23, 1'b0, 2'h0}: s = mk(1'b0, 1'b1, 1'b1, SW_HOME, 1'b1);
      {MODE_HOME_23, 1'b0, 2'h1}: s = mk(1'b1, 1'b0, 1'b0, SW_HOME, 1'b0);
      // Sensor on, also the path taken after reversing at the positive limit
      {MODE_HOME_23, 1'b1, 2'h0}: s = mk(1'b0, 1'b0, 1'b1, SW_HOME, 1'b0);
      {MODE_HOME_23, 1'b1, 2'h1}: s = mk(1'b0, 1'b1, 1'b1, SW_HOME, 1'b1);
      {MODE_HOME_23, 1'b1, 2'h2}: s = mk(1'b1, 1'b0, 1'b0, SW_HOME, 1'b0);
      default: s = mk(1'b1, 1'b0, 1'b0, SW_HOME, 1'b0);
    endcase
    return s;
  endfunction

  // ==========================================================================
  // Switch synchronisers and edge detection

  logic [2:0] sw_meta_ff;
  logic [2:0] sw_sync_ff;
  logic [2:0] sw_prev_ff;
  wire [2:0] sw_pins = {home_sensor_switch, positive_limit_switch, negative_limit_switch};

  // Two stages for the pins, a third stage only for edges
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sw_meta_ff <= SW_RST;
      sw_sync_ff <= SW_RST;
      sw_prev_ff <= SW_RST;
    end else begin
      sw_meta_ff <= sw_pins;
      sw_sync_ff <= sw_meta_ff;
      sw_prev_ff <= sw_sync_ff;
    end
  end

  // Edges come from the settled stage only; the first stage may still be metastable
  wire [2:0] sw_rise = sw_sync_ff & ~sw_prev_ff;
  wire [2:0] sw_fall = ~sw_sync_ff & sw_prev_ff;
  wire nl_on = sw_sync_ff[SW_NEG];
  wire pl_on = sw_sync_ff[SW_POS];
  wire hsw_on = sw_sync_ff[SW_HOME];

  // ==========================================================================
  // Sequencer state

  state_t state_ff;
  state_t nxt_state;
  logic [7:0] mode_ff;
  logic [7:0] nxt_mode;
  logic var_ff;
  logic nxt_var;
  logic [1:0] step_ff;
  logic [1:0] nxt_step;
  logic hold_ff;
  logic nxt_hold;
  logic pl_seen_ff;
  logic nxt_pl_seen;
  logic alarm_ff;
  logic nxt_alarm;
  logic home_set_ff;
  logic nxt_home_set;
  logic done_ff;
  logic nxt_done;
  logic dir_ff;
  logic fast_ff;

  // Decodes of the current segment and method
  seg_t cur;
  seg_t nxt_seg;
  assign cur = seg_lookup(mode_ff, var_ff, step_ff);
  assign nxt_seg = seg_lookup(nxt_mode, nxt_var, nxt_step);
  wire seg_hit = cur.to_active ? sw_rise[cur.sw] : sw_fall[cur.sw];
  // Reserved 15 and 16 lie below this window and are refused like any stray value
  wire mode_ok = (mode >= MODE_NEG_LIMIT) && (mode <= MODE_HOME_23);
  wire in_19_22 = (mode_ff >= MODE_HOME_19) && (mode_ff <= MODE_HOME_22);
  wire in_23 = (mode_ff == MODE_HOME_23);

  // Watched switch level at start picks the branch of the method
  wire start_var = (mode == MODE_NEG_LIMIT) ? nl_on : (mode == MODE_POS_LIMIT) ? pl_on : hsw_on;

  // First positive limit on the opening positive run of mode 23 reverses
  wire reverse_now = in_23 && !pl_seen_ff && pl_on && !var_ff && (step_ff == 2'h0);
  // Limits in the middle of a run end it with an alarm
  wire trip_19_22 = in_19_22 && (nl_on || pl_on);
  wire trip_23 = in_23 && (nl_on || (pl_seen_ff ? sw_rise[SW_POS] : (pl_on && !reverse_now)));
  wire trip = trip_19_22 || trip_23;

  // Next-state logic; abort outranks reversal, reversal outranks the segment edge
  always_comb begin
    nxt_state = state_ff;
    nxt_mode = mode_ff;
    nxt_var = var_ff;
    nxt_step = step_ff;
    nxt_hold = hold_ff;
    nxt_pl_seen = pl_seen_ff;
    nxt_alarm = alarm_ff;
    nxt_home_set = 1'b0;
    nxt_done = 1'b0;
    case (state_ff)
      ST_IDLE: begin
        if (start) begin
          // Reserved and unknown methods are refused with the alarm
          nxt_alarm = !mode_ok;
          if (mode_ok) begin
            nxt_state = ST_RUN;
            nxt_mode = mode;
            nxt_var = start_var;
            nxt_step = STEP_RST;
            nxt_hold = 1'b0;
            nxt_pl_seen = 1'b0;
          end
        end
      end
      ST_RUN: begin
        if (trip) begin
          nxt_state = ST_ABORT;
          nxt_alarm = 1'b1;
        end else if (reverse_now) begin
          // Stop at the limit, then run the sensor-on path
          nxt_state = ST_STOP;
          nxt_pl_seen = 1'b1;
          nxt_var = 1'b1;
          nxt_step = STEP_RST;
          nxt_hold = 1'b1;
        end else if (seg_hit) begin
          nxt_state = ST_STOP;
        end
      end
      ST_STOP: begin
        // Limits stay watched while the axis ramps down
        if (trip && !reverse_now) begin
          nxt_state = ST_ABORT;
          nxt_alarm = 1'b1;
        end else if (axis_stopped) begin
          if (hold_ff) begin
            nxt_hold = 1'b0;
            nxt_state = ST_RUN;
          end else if (cur.last) begin
            nxt_state = ST_IDLE;
            nxt_home_set = 1'b1;
            nxt_done = 1'b1;
          end else begin
            nxt_step = step_ff + 2'h1;
            nxt_state = ST_RUN;
          end
        end
      end
      ST_ABORT: begin
        if (axis_stopped) begin
          nxt_state = ST_IDLE;
          nxt_done = 1'b1;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  // Registers of the sequencer
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_ff <= ST_IDLE;
      mode_ff <= MODE_RST;
      var_ff <= 1'b0;
      step_ff <= STEP_RST;
      hold_ff <= 1'b0;
      pl_seen_ff <= 1'b0;
      alarm_ff <= 1'b0;
      home_set_ff <= 1'b0;
      done_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      mode_ff <= nxt_mode;
      var_ff <= nxt_var;
      step_ff <= nxt_step;
      hold_ff <= nxt_hold;
      pl_seen_ff <= nxt_pl_seen;
      alarm_ff <= nxt_alarm;
      home_set_ff <= nxt_home_set;
      done_ff <= nxt_done;
    end
  end

  // Motion command registers; direction held through the ramp-down
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      dir_ff <= 1'b0;
      fast_ff <= 1'b0;
    end else if (nxt_state == ST_RUN) begin
      dir_ff <= nxt_seg.dir_pos;
      fast_ff <= nxt_seg.fast;
    end
  end

  // ==========================================================================
  // Outputs; speeds and ramps themselves stay with the controller
  assign move_run = (state_ff == ST_RUN);
  assign move_dir_pos = dir_ff;
  assign move_fast = fast_ff;
  assign busy = (state_ff != ST_IDLE);
  assign home_set = home_set_ff;
  assign done = done_ff;
  assign alarm = alarm_ff;

endmodule

// ### dv/homing_sequencer_chk.sv
// Port checker for the homing sequencer.
// Assumes switch pins settle two edges before a start is given.
`timescale 1ns/10ps
module homing_sequencer_chk
  import homing_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Command and motion
  input wire logic start,
  input wire logic [7:0] mode,
  input wire logic axis_stopped,
  input wire logic move_run,
  input wire logic move_dir_pos,
  input wire logic move_fast,
  // Status
  input wire logic busy,
  input wire logic home_set,
  input wire logic done,
  input wire logic alarm,
  // Switches
  input wire logic negative_limit_switch,
  input wire logic positive_limit_switch,
  input wire logic home_sensor_switch
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ==========================================================================
  // Method latched at the taken start, since mode may change mid-run
  logic [7:0] run_mode_ff;
  wire logic take = start && !busy;
  wire logic mid = run_mode_ff >= MODE_HOME_19 && run_mode_ff <= MODE_HOME_22;
  always_ff @(posedge clk) begin
    if (!rst_n) run_mode_ff <= MODE_RST;
    else if (take) run_mode_ff <= mode;
  end
  // ==========================================================================
  // First segment; $past by 2 matches the two-stage switch synchroniser
  property p_m17_off;
    take && mode == MODE_NEG_LIMIT && !$past(negative_limit_switch, 2) |=> move_run && !move_dir_pos && move_fast;
  endproperty
  a_m17_off: assert property (p_m17_off) else $error("mode 17 first move wrong");
  property p_m17_on;
    take && mode == MODE_NEG_LIMIT && $past(negative_limit_switch, 2) |=> move_run && move_dir_pos && !move_fast;
  endproperty
  a_m17_on: assert property (p_m17_on) else $error("mode 17 creep move wrong");
  property p_m18_off;
    take && mode == MODE_POS_LIMIT && !$past(positive_limit_switch, 2) |=> move_run && move_dir_pos && move_fast;
  endproperty
  a_m18_off: assert property (p_m18_off) else $error("mode 18 first move wrong");
  property p_m18_on;
    take && mode == MODE_POS_LIMIT && $past(positive_limit_switch, 2) |=> move_run && !move_dir_pos && !move_fast;
  endproperty
  a_m18_on: assert property (p_m18_on) else $error("mode 18 creep move wrong");
  property p_m19_on;
    take && mode == MODE_HOME_19 && $past(home_sensor_switch, 2) |=> move_run && !move_dir_pos && move_fast;
  endproperty
  a_m19_on: assert property (p_m19_on) else $error("mode 19 first move wrong");
  property p_m22_on;
    take && mode == MODE_HOME_22 && $past(home_sensor_switch, 2) |=> move_run && move_dir_pos && move_fast;
  endproperty
  a_m22_on: assert property (p_m22_on) else $error("mode 22 first move wrong");
  // ==========================================================================
  // Aborts, home pulse and stop handshake
  property p_abort;
    busy && mid && ($past(negative_limit_switch, 2) || $past(positive_limit_switch, 2))
      |=> alarm && !move_run && !home_set;
  endproperty
  a_abort: assert property (p_abort) else $error("limit did not abort");
  property p_m23_nl;
    busy && run_mode_ff == MODE_HOME_23 && $past(negative_limit_switch, 2) |=> alarm && !move_run;
  endproperty
  a_m23_nl: assert property (p_m23_nl) else $error("mode 23 negative limit did not abort");
  property p_home; home_set |-> done && !alarm && !busy && $past(axis_stopped); endproperty
  a_home: assert property (p_home) else $error("home taken while not stopped");
  property p_stop_wait; busy && !move_run && !axis_stopped |=> !move_run; endproperty
  a_stop_wait: assert property (p_stop_wait) else $error("moved before standstill");
  c_home: cover property (home_set);
  c_abort: cover property (done && alarm);
  c_refused: cover property (take ##1 alarm && !busy);
endmodule
bind homing_sequencer homing_sequencer_chk chk (.clk(clk), .rst_n(rst_n), .start(start), .mode(mode),
  .axis_stopped(axis_stopped), .move_run(move_run), .move_dir_pos(move_dir_pos), .move_fast(move_fast),
  .busy(busy), .home_set(home_set), .done(done), .alarm(alarm), .negative_limit_switch(negative_limit_switch),
  .positive_limit_switch(positive_limit_switch), .home_sensor_switch(home_sensor_switch));

// ### dv/axis_model.sv
// Axis model: position counter with two limits and a home sensor band.
// Assumes the bench loads a start position while the axis stands still.
`timescale 1ns/10ps
module axis_model (
  // Clock, reset and bench set-up
  input wire logic clk,
  input wire logic rst_n,
  input wire logic load,
  input wire logic signed [31:0] load_pos,
  input wire logic sensor_en,
  input wire logic [2:0] decel,
  // Motion commands
  input wire logic move_run,
  input wire logic move_dir_pos,
  input wire logic move_fast,
  output logic axis_stopped = 1'b1,
  // Switches, high active
  output logic negative_limit_switch,
  output logic positive_limit_switch,
  output logic home_sensor_switch
);
  int pos = 0;
  logic [2:0] cnt = 3'h0;
  // Creep 1, search 4 per cycle; the ramp is folded into a stop delay
  always @(posedge clk) begin
    if (!rst_n || load) begin
      cnt <= decel;
      axis_stopped <= 1'b1;
      if (load) pos <= load_pos;
    end else if (move_run) begin
      pos <= move_dir_pos ? pos + (move_fast ? 4 : 1) : pos - (move_fast ? 4 : 1);
      cnt <= decel;
      axis_stopped <= 1'b0;
    end else if (cnt != 3'h0) cnt <= cnt - 3'h1;
    else axis_stopped <= 1'b1;
  end
  // Switch map: limits at both ends, sensor band may be left out
  assign negative_limit_switch = pos <= 0;
  assign positive_limit_switch = pos >= 1000;
  assign home_sensor_switch = sensor_en && pos >= 400 && pos <= 500;
endmodule

// ### dv/tb_top.sv
// Self-checking bench: runs every method from both switch states.
// Assumes the axis model answers; results are queued and matched on done.
`timescale 1ns/10ps
module tb_top
  import homing_pkg::*;
;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic start = 1'b0;
  logic [7:0] mode = 8'h00;
  logic load = 1'b0;
  logic sensor_en = 1'b1;
  logic [2:0] decel = 3'h0;
  logic [31:0] rng = 32'h0000_8408;
  int load_pos = 0;
  int mismatches = 0;
  int checks = 0;
  int cycles = 0;
  wire logic axis_stopped, move_run, move_dir_pos, move_fast, busy, home_set, done, alarm, neg_sw, pos_sw, home_sw;
  typedef struct {logic [7:0] m; int p; logic s; logic h; int at;} row_t;
  typedef struct {logic h; int at;} exp_t;
  exp_t notes[$];
  exp_t e;
  // Method, start position, sensor fitted, home expected, edge position
  row_t rows[18] = '{
    '{8'h11, 200, 1'b1, 1'b1, 0}, '{8'h11, -3, 1'b1, 1'b1, 0},
    '{8'h12, 700, 1'b1, 1'b1, 1000}, '{8'h12, 1003, 1'b1, 1'b1, 1000},
    '{8'h13, 200, 1'b1, 1'b1, 400}, '{8'h13, 450, 1'b1, 1'b1, 400},
    '{8'h14, 200, 1'b1, 1'b1, 400}, '{8'h14, 450, 1'b1, 1'b1, 400},
    '{8'h15, 700, 1'b1, 1'b1, 500}, '{8'h15, 450, 1'b1, 1'b1, 500},
    '{8'h16, 700, 1'b1, 1'b1, 500}, '{8'h16, 450, 1'b1, 1'b1, 500},
    '{8'h17, 700, 1'b1, 1'b1, 400}, '{8'h17, 200, 1'b1, 1'b1, 400},
    '{8'h17, 450, 1'b1, 1'b1, 400}, '{8'h15, 300, 1'b0, 1'b0, 0},
    '{8'h13, 700, 1'b0, 1'b0, 0}, '{8'h17, 200, 1'b0, 1'b0, 0}};
  homing_sequencer dut (.clk(clk), .rst_n(rst_n), .start(start), .mode(mode), .axis_stopped(axis_stopped),
    .move_run(move_run), .move_dir_pos(move_dir_pos), .move_fast(move_fast), .busy(busy), .home_set(home_set),
    .done(done), .alarm(alarm), .negative_limit_switch(neg_sw), .positive_limit_switch(pos_sw),
    .home_sensor_switch(home_sw));
  axis_model axis (.clk(clk), .rst_n(rst_n), .load(load), .load_pos(load_pos), .sensor_en(sensor_en),
    .decel(decel), .move_run(move_run), .move_dir_pos(move_dir_pos), .move_fast(move_fast),
    .axis_stopped(axis_stopped), .negative_limit_switch(neg_sw), .positive_limit_switch(pos_sw),
    .home_sensor_switch(home_sw));
  always #4 clk = ~clk;
  // ==========================================================================
  // Helpers
  function automatic logic [31:0] next_rnd(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task automatic check_val(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (exp !== got) begin
      mismatches++;
      $display("mismatch %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // One run: random jitter in start place and stop delay, then wait for done
  task automatic run_row(input row_t r);
    rng = next_rnd(rng);
    load_pos = r.p + ((r.p > 100 && r.p < 900) ? int'(rng[2:0]) : 0);
    decel = rng[5:3];
    sensor_en = r.s;
    load = 1'b1;
    @(negedge clk);
    load = 1'b0;
    repeat (3) @(negedge clk);
    mode = r.m;
    start = 1'b1;
    notes.push_back('{r.h, r.at});
    do @(negedge clk); while (busy === 1'b1);
    start = 1'b0;
  endtask
  // ==========================================================================
  // Result monitor: oldest note against each done pulse
  always @(negedge clk) begin
    if (done === 1'b1) begin
      if (notes.size() == 0) begin
        // A done with no accepted start behind it; a refused method pulses no done
        check_val("done without start", 32'h0, done);
      end else begin
        e = notes.pop_front();
        check_val("home_set", e.h, home_set);
        check_val("alarm", !e.h, alarm);
        if (e.h) check_val("home near edge", 1, axis.pos <= e.at + 6 && axis.pos >= e.at - 6);
      end
    end
  end
  // Hang guard, far above the expected run length
  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      mismatches++;
      finish_test();
    end
  end
  initial begin
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    check_val("idle outputs", 32'h0, {move_run, busy, done, alarm, home_set});
    // Out-of-range method first, while alarm is still clear; 15 and 16 are never selected
    repeat (2) @(negedge clk);
    mode = 8'h18;
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
    check_val("refused busy", 32'h0, busy);
    check_val("refused alarm", 32'h1, alarm);
    foreach (rows[i]) run_row(rows[i]);
    repeat (4) @(negedge clk);
    check_val("pending results", 32'h0, notes.size());
    finish_test();
  end
endmodule
